// File: core/fpio_pkg.sv
`default_nettype none
package fpio_pkg;
    localparam int FPIO_W = 8;
    localparam int FPIO_AW = 4;
    localparam logic [3:0] FPIO_ADDR_DATA_A = 4'h0;
    localparam logic [3:0] FPIO_ADDR_DATA_B = 4'h1;
    localparam logic [3:0] FPIO_ADDR_DATA_C = 4'h2;
    localparam logic [3:0] FPIO_ADDR_DATA_D = 4'h3;
    localparam logic [3:0] FPIO_ADDR_DIR_A = 4'h4;
    localparam logic [3:0] FPIO_ADDR_DIR_B = 4'h5;
    localparam logic [3:0] FPIO_ADDR_DIR_C = 4'h6;
    localparam logic [3:0] FPIO_ADDR_CLKCTL = 4'h7;
    localparam logic [3:0] FPIO_ADDR_CONV = 4'h9;
    localparam int FPIO_CONV_ON_BIT = 5;
    localparam int FPIO_CLK_SEL_BIT = 3;
    localparam int FPIO_CLK_PIN_BIT = 2;
    localparam logic [7:0] FPIO_DIR_RESET = 8'h00;
    localparam logic [7:0] FPIO_CONV_RESET = 8'h00;
    localparam logic [7:0] FPIO_CONV_WMASK = 8'h6F;
    localparam logic [7:0] FPIO_CLKCTL_WMASK = 8'h08;
    localparam logic [7:0] FPIO_ZERO = 8'h00;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } fpio_bytes_t;
endpackage : fpio_pkg
`default_nettype wire

// File: core/fpio_sync.sv
`default_nettype none
module fpio_sync
    import fpio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("fpio_sync: WIDTH must be positive");
        end
    end

    // First stage is read only by the second stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : fpio_sync
`default_nettype wire

// File: core/fpio_top.sv
// Operation
// - Port D is an eight-bit input-only port, readable at any time.
// - Port D has no direction control and never drives its pins.
// - Converter-on bit 5 at 0x09 makes port D pins analog inputs.
// - Reset clears the converter control register, port D is digital.
// - Port A, B, C data latches at 0x00-0x02, not reset.
// - Port D data at 0x03 returns pin n level in bit n, read-only.
// - Each bit of A, B, C has its own direction bit.
// - With clock output selected, port C bit 2 drives the CPU clock.
// - Direction registers at 0x04-0x06; one means output.
// - Reset clears all direction registers, every pin an input.
// - Zero latch plus toggled direction gives open-drain behaviour.
// - Data read returns latch for outputs, pin level for inputs.
// - Data writes always load the latch; pins driven only as outputs.
// - Clock output forces bit 2 to output and reads return its latch.
// - Direction registers read back the last value written.
//
// Added by the designer: the plain strobed port.
`default_nettype none
module fpio_top
    import fpio_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] pin_a_in,
    output logic [7:0] pin_a_out,
    output logic [7:0] pin_a_oe_n,
    input wire logic [7:0] pin_b_in,
    output logic [7:0] pin_b_out,
    output logic [7:0] pin_b_oe_n,
    input wire logic [7:0] pin_c_in,
    output logic [7:0] pin_c_out,
    output logic [7:0] pin_c_oe_n,
    input wire logic [7:0] input_only_pins,
    output logic converter_on,
    output logic [6:0] converter_ctl,
    input wire logic conversion_complete
);
    fpio_bytes_t latch_reg, latch_next;
    fpio_bytes_t dir_reg, dir_next;
    logic [7:0] conv_reg, conv_next;
    logic clk_sel_reg, clk_sel_next;
    logic [7:0] rdata_reg, rdata_next;
    logic clk_div_reg, clk_div_next;
    fpio_bytes_t out_reg, out_next;
    fpio_bytes_t oe_n_reg, oe_n_next;
    logic [7:0] sync_a, sync_b, sync_c, sync_d, sync_misc;
    logic conversion_complete_sync;
    logic [7:0] dir_c_eff;

    fpio_sync #(.WIDTH(8)) u_sync_a (
        .mclk(mclk), .rst(rst), .async_in(pin_a_in), .sync_out(sync_a)
    );
    fpio_sync #(.WIDTH(8)) u_sync_b (
        .mclk(mclk), .rst(rst), .async_in(pin_b_in), .sync_out(sync_b)
    );
    fpio_sync #(.WIDTH(8)) u_sync_c (
        .mclk(mclk), .rst(rst), .async_in(pin_c_in), .sync_out(sync_c)
    );
    fpio_sync #(.WIDTH(8)) u_sync_d (
        .mclk(mclk), .rst(rst), .async_in(input_only_pins),
        .sync_out(sync_d)
    );
    fpio_sync #(.WIDTH(8)) u_sync_misc (
        .mclk(mclk), .rst(rst), .async_in({7'h00, conversion_complete}),
        .sync_out(sync_misc)
    );
    assign conversion_complete_sync = sync_misc[0];

    // Mix latch and pin per bit: latch for outputs, pin for inputs
    function automatic logic [7:0] mix_read(input logic [7:0] dir,
                                            input logic [7:0] latch,
                                            input logic [7:0] pin);
        mix_read = (dir & latch) | (~dir & pin);
    endfunction : mix_read

    always_comb begin
        dir_c_eff = dir_reg.c;
        if (clk_sel_reg) begin
            dir_c_eff[FPIO_CLK_PIN_BIT] = 1'b1;
        end
    end

    // Data latches: no reset, their power-up content is undefined
    always_comb begin
        latch_next = latch_reg;
        if (bus_wr) begin
            case (bus_addr)
                FPIO_ADDR_DATA_A: latch_next.a = bus_wdata;
                FPIO_ADDR_DATA_B: latch_next.b = bus_wdata;
                FPIO_ADDR_DATA_C: latch_next.c = bus_wdata;
                default: latch_next = latch_reg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        latch_reg <= latch_next;
    end

    always_comb begin
        dir_next = dir_reg;
        conv_next = conv_reg;
        clk_sel_next = clk_sel_reg;
        if (bus_wr) begin
            case (bus_addr)
                FPIO_ADDR_DIR_A: dir_next.a = bus_wdata;
                FPIO_ADDR_DIR_B: dir_next.b = bus_wdata;
                FPIO_ADDR_DIR_C: dir_next.c = bus_wdata;
                FPIO_ADDR_CLKCTL: begin
                    clk_sel_next = bus_wdata[FPIO_CLK_SEL_BIT];
                end
                FPIO_ADDR_CONV: begin
                    conv_next = bus_wdata & FPIO_CONV_WMASK;
                end
                default: dir_next = dir_reg;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir_reg <= {FPIO_DIR_RESET, FPIO_DIR_RESET, FPIO_DIR_RESET};
            conv_reg <= FPIO_CONV_RESET;
            clk_sel_reg <= 1'b0;
        end else begin
            dir_reg <= dir_next;
            conv_reg <= conv_next;
            clk_sel_reg <= clk_sel_next;
        end
    end

    // Read data stands the cycle after the read strobe only
    always_comb begin
        rdata_next = FPIO_ZERO;
        if (bus_rd) begin
            case (bus_addr)
                FPIO_ADDR_DATA_A:
                    rdata_next = mix_read(dir_reg.a, latch_reg.a, sync_a);
                FPIO_ADDR_DATA_B:
                    rdata_next = mix_read(dir_reg.b, latch_reg.b, sync_b);
                FPIO_ADDR_DATA_C:
                    rdata_next = mix_read(dir_c_eff, latch_reg.c, sync_c);
                FPIO_ADDR_DATA_D: rdata_next = sync_d;
                FPIO_ADDR_DIR_A: rdata_next = dir_reg.a;
                FPIO_ADDR_DIR_B: rdata_next = dir_reg.b;
                FPIO_ADDR_DIR_C: rdata_next = dir_reg.c;
                FPIO_ADDR_CLKCTL:
                    rdata_next = {4'h0, clk_sel_reg, 3'h0};
                FPIO_ADDR_CONV:
                    rdata_next = {conversion_complete_sync, conv_reg[6:0]};
                default: rdata_next = FPIO_ZERO;
            endcase
        end
    end

    // Pin drive; clock output is mclk halved since outputs must be flopped
    always_comb begin
        clk_div_next = clk_sel_reg ? ~clk_div_reg : 1'b0;
        out_next = latch_next;
        oe_n_next.a = ~dir_next.a;
        oe_n_next.b = ~dir_next.b;
        oe_n_next.c = ~dir_next.c;
        if (clk_sel_next) begin
            out_next.c[FPIO_CLK_PIN_BIT] = clk_div_next;
            oe_n_next.c[FPIO_CLK_PIN_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= FPIO_ZERO;
            clk_div_reg <= 1'b0;
            out_reg <= {FPIO_ZERO, FPIO_ZERO, FPIO_ZERO};
            oe_n_reg <= {8'hFF, 8'hFF, 8'hFF};
        end else begin
            rdata_reg <= rdata_next;
            clk_div_reg <= clk_div_next;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign pin_a_out = out_reg.a;
    assign pin_b_out = out_reg.b;
    assign pin_c_out = out_reg.c;
    assign pin_a_oe_n = oe_n_reg.a;
    assign pin_b_oe_n = oe_n_reg.b;
    assign pin_c_oe_n = oe_n_reg.c;
    // Port D has no drive path at all; analog muxing is outside
    assign converter_on = conv_reg[FPIO_CONV_ON_BIT];
    assign converter_ctl = conv_reg[6:0];

    chk_dir_write: assert property (@(posedge mclk) disable iff (rst)
        bus_wr && bus_addr == FPIO_ADDR_DIR_A |=> dir_reg.a == $past(bus_wdata))
        else $error("direction A write not stored");

    chk_oe_follow: assert property (@(posedge mclk) disable iff (rst)
        bus_wr && bus_addr == FPIO_ADDR_DIR_B
        |=> pin_b_oe_n == ~$past(bus_wdata))
        else $error("port B enable does not follow direction");

    chk_latch_pin: assert property (@(posedge mclk) disable iff (rst)
        bus_wr && bus_addr == FPIO_ADDR_DATA_A |=> pin_a_out == $past(bus_wdata))
        else $error("port A latch not on pin");

    sequence s_read_d;
        bus_rd && bus_addr == FPIO_ADDR_DATA_D;
    endsequence

    chk_read_d: assert property (@(posedge mclk) disable iff (rst)
        s_read_d |=> bus_rdata == $past(sync_d))
        else $error("port D read wrong");

    chk_read_mix: assert property (@(posedge mclk) disable iff (rst)
        bus_rd && bus_addr == FPIO_ADDR_DATA_B |=> bus_rdata ==
        (($past(dir_reg.b) & $past(latch_reg.b)) |
         (~$past(dir_reg.b) & $past(sync_b))))
        else $error("port B read mix wrong");

    chk_dir_read: assert property (@(posedge mclk) disable iff (rst)
        bus_rd && bus_addr == FPIO_ADDR_DIR_C |=> bus_rdata == $past(dir_reg.c))
        else $error("direction C readback wrong");

    chk_clk_drive: assert property (@(posedge mclk) disable iff (rst)
        clk_sel_reg && $past(clk_sel_reg) |-> !pin_c_oe_n[FPIO_CLK_PIN_BIT])
        else $error("clock pin not driven");

    chk_clk_toggle: assert property (@(posedge mclk) disable iff (rst)
        clk_sel_reg && $past(clk_sel_reg) |=>
        pin_c_out[FPIO_CLK_PIN_BIT] != $past(pin_c_out[FPIO_CLK_PIN_BIT]))
        else $error("clock pin not toggling");

    chk_conv_on: assert property (@(posedge mclk) disable iff (rst)
        bus_wr && bus_addr == FPIO_ADDR_CONV
        |=> converter_on == $past(bus_wdata[FPIO_CONV_ON_BIT]))
        else $error("converter on bit wrong");

    chk_idle_rd: assert property (@(posedge mclk) disable iff (rst)
        !bus_rd |=> bus_rdata == FPIO_ZERO)
        else $error("read data outside read slot");
endmodule : fpio_top
`default_nettype wire

// File: bench/fpio_pins.sv
`default_nettype none
module fpio_pins
    import fpio_pkg::*;
(
    input wire fpio_bytes_t pin_out,
    input wire fpio_bytes_t pin_oe_n,
    input wire fpio_bytes_t ext_lvl,
    output fpio_bytes_t pin_lvl
);
    // A driven bit shows the latch, a released bit the outside level
    assign pin_lvl = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule : fpio_pins
`default_nettype wire

// File: bench/fpio_top_tb.sv
`default_nettype none
module fpio_top_tb
    import fpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [3:0] wa;
        logic [7:0] wd;
        logic [3:0] ra;
        logic [7:0] ex;
    } fpio_row_t;
    logic mclk, rst, bus_wr, bus_rd, cc;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, dpins, q, b0;
    logic conv_on;
    fpio_bytes_t pout, poe, plvl, ext;
    int num_errors, checks;
    fpio_row_t rows [10];
    fpio_top dut_u (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .pin_a_in(plvl.a), .pin_a_out(pout.a),
        .pin_a_oe_n(poe.a), .pin_b_in(plvl.b), .pin_b_out(pout.b),
        .pin_b_oe_n(poe.b), .pin_c_in(plvl.c), .pin_c_out(pout.c),
        .pin_c_oe_n(poe.c), .input_only_pins(dpins),
        .converter_on(conv_on), .converter_ctl(),
        .conversion_complete(cc));
    fpio_pins pins_u (.pin_out(pout), .pin_oe_n(poe), .ext_lvl(ext),
        .pin_lvl(plvl));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        rows = '{'{4'h4, 8'hF0, 4'h4, 8'hF0}, '{4'h0, 8'h5A, 4'h0, 8'h53},
            '{4'h5, 8'hFF, 4'h5, 8'hFF}, '{4'h1, 8'h3C, 4'h1, 8'h3C},
            '{4'h6, 8'h00, 4'h6, 8'h00}, '{4'h2, 8'h77, 4'h2, 8'h0F},
            '{4'h3, 8'hFF, 4'h3, 8'hA5}, '{4'h8, 8'h12, 4'h8, 8'h00},
            '{4'h9, 8'hAF, 4'h9, 8'h2F}, '{4'h9, 8'h00, 4'h9, 8'h00}};
        num_errors = 0;
        checks = 0;
        {bus_wr, bus_rd, cc, bus_addr, bus_wdata} = '0;
        rst = 1'b1;
        dpins = 8'hA5;
        ext = '{a: 8'h33, b: 8'hC3, c: 8'h0F};
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int i = 4; i < 7; i++) begin
            rd(i[3:0], q);
            check(q, FPIO_DIR_RESET);
        end
        rd(FPIO_ADDR_CONV, q);
        check(q, FPIO_CONV_RESET);
        check({poe.a & poe.b, poe.c}, 16'hFFFF);
        $display("test reset done");
        // Port D is read before the converter is switched on
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, q);
            check(q, rows[i].ex);
            if (i == 8) check({7'h00, conv_on}, 8'h01);
        end
        check({7'h00, conv_on}, 8'h00);
        check(pout.a, 8'h5A);
        check(poe.a, 8'h0F);
        check(poe.c, 8'hFF);
        $display("test table done");
        // Latch cleared once, then direction writes only, never read-modify-write of the latch
        wr(FPIO_ADDR_DATA_C, 8'h00);
        wr(FPIO_ADDR_DIR_C, 8'h04);
        check({poe.c, pout.c & 8'h04}, 16'hFB00);
        wr(FPIO_ADDR_DIR_C, 8'h00);
        check(poe.c, 8'hFF);
        $display("test open drain done");
        wr(FPIO_ADDR_CLKCTL, 8'h08);
        check(poe.c, 8'hFB);
        b0 = {7'h00, pout.c[2]};
        @(posedge mclk);
        #1;
        check({7'h00, pout.c[2]}, ~b0 & 8'h01);
        repeat (3) @(posedge mclk);
        rd(FPIO_ADDR_DATA_C, q);
        check(q, 8'h0B);
        rd(FPIO_ADDR_DIR_C, q);
        check(q, 8'h00);
        wr(FPIO_ADDR_CLKCTL, 8'h00);
        check(poe.c, 8'hFF);
        $display("test clock out done");
        wr(FPIO_ADDR_CONV, 8'h20);
        wr(FPIO_ADDR_DIR_B, 8'h81);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        check({7'h00, conv_on}, 8'h00);
        check(poe.b, 8'hFF);
        rst <= 1'b0;
        rd(FPIO_ADDR_DIR_B, q);
        check(q, FPIO_DIR_RESET);
        $display("test mid reset done");
        complete_run();
    end
endmodule : fpio_top_tb
`default_nettype wire
